// ===== hdl/sense_amp_control.v
// SPI register bank for the current-sense amplifiers and drive strength.
// Assumes SCLK runs at most one eighth of clk_in; all pins are resynced.
`timescale 1ns/10ps
`include "sense_amp_defs.vh"

module sense_amp_control #(
  parameter HAS_AMPS = 1,
  parameter SPI_VARIANT = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Serial register port
  input wire spi_sclk_in,
  input wire spi_cs_n_in,
  input wire spi_sdi_in,
  output reg spi_sdo_out,
  output reg spi_sdo_oe_n_out,
  // Hardware variant drive strength pin code
  input wire [3:0] drive_strength_pin_in,
  // Analog status inputs
  input wire sense_overcurrent_in,
  input wire gate_drive_cmd_in,
  input wire gate_on_ok_in,
  // Amplifier configuration
  output reg amp_input_select_out,
  output reg ref_half_out,
  output reg lowside_monitor_ref_select_out,
  output reg [5:0] amp_gain_vv_out,
  output reg [2:0] offset_cal_short_out,
  output reg [9:0] sense_trip_mv_out,
  output reg sense_fault_out,
  // Gate drive configuration
  output reg [3:0] drive_source_hs_out,
  output reg [3:0] drive_sink_hs_out,
  output reg [3:0] drive_source_ls_out,
  output reg [3:0] drive_sink_ls_out,
  output reg gate_drive_fault_out,
  output reg locked_out
);

  // Pin synchronisers
  reg [1:0] sclk_sync;
  reg [1:0] cs_sync;
  reg [1:0] sdi_sync;
  reg [1:0] socp_sync;
  reg [1:0] gcmd_sync;
  reg [1:0] gok_sync;
  reg [3:0] pin_meta;
  reg [3:0] pin_code;
  reg sclk_prev;
  reg gcmd_prev;

  always @(posedge clk_in) begin
    if (reset_in) begin
      sclk_sync <= 2'h0;
      cs_sync <= 2'h3;
      sdi_sync <= 2'h0;
      socp_sync <= 2'h0;
      gcmd_sync <= 2'h0;
      gok_sync <= 2'h0;
      pin_meta <= 4'h0;
      pin_code <= 4'h0;
      sclk_prev <= 1'b0;
      gcmd_prev <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], spi_sclk_in};
      cs_sync <= {cs_sync[0], spi_cs_n_in};
      sdi_sync <= {sdi_sync[0], spi_sdi_in};
      socp_sync <= {socp_sync[0], sense_overcurrent_in};
      gcmd_sync <= {gcmd_sync[0], gate_drive_cmd_in};
      gok_sync <= {gok_sync[0], gate_on_ok_in};
      pin_meta <= drive_strength_pin_in;
      pin_code <= pin_meta;
      sclk_prev <= sclk_sync[1];
      gcmd_prev <= gcmd_sync[1];
    end
  end

  wire cs_active = ~cs_sync[1];
  wire sclk_rise = sclk_sync[1] & ~sclk_prev;
  wire sclk_fall = ~sclk_sync[1] & sclk_prev;

  // Register state
  reg [10:0] amp_ctrl;
  reg [10:0] drv_ctrl;
  reg [7:0] gate_hs;
  reg [10:0] gate_ls;
  reg locked;
  reg gate_fault;

  // Frame state
  reg [4:0] bit_count;
  reg [15:0] in_shift;
  reg [10:0] out_shift;

  wire [15:0] frame = {in_shift[14:0], sdi_sync[1]};
  wire frame_done = cs_active & sclk_fall & (bit_count == 5'd15);
  wire wr_req = frame_done & ~frame[15];
  wire [3:0] wr_addr = frame[14:11];
  wire [10:0] wr_data = frame[10:0];
  wire [3:0] rd_addr = {in_shift[2:0], sdi_sync[1]};

  reg [10:0] rd_data;
  always @* begin
    if (rd_addr == `ADDR_STATUS)
      rd_data = {gate_fault, 10'h000};
    else if (rd_addr == `ADDR_DRV_CTRL)
      rd_data = drv_ctrl;
    else if (rd_addr == `ADDR_GATE_HS)
      rd_data = {(locked ? `LOCK_CODE : `UNLOCK_CODE), gate_hs};
    else if (rd_addr == `ADDR_GATE_LS)
      rd_data = gate_ls;
    else if (rd_addr == `ADDR_AMP_CTRL && HAS_AMPS != 0)
      rd_data = amp_ctrl;
    else
      rd_data = 11'h000;
  end

  // Serial shift, capture on falling SCLK, launch on rising SCLK
  always @(posedge clk_in) begin
    if (reset_in) begin
      bit_count <= 5'd0;
      in_shift <= 16'h0000;
      out_shift <= 11'h000;
      spi_sdo_out <= 1'b0;
      spi_sdo_oe_n_out <= 1'b1;
    end else begin
      spi_sdo_oe_n_out <= ~cs_active;
      if (!cs_active) begin
        bit_count <= 5'd0;
        out_shift <= 11'h000;
        spi_sdo_out <= 1'b0;
      end else begin
        if (sclk_fall) begin
          in_shift <= frame;
          if (bit_count != 5'd16)
            bit_count <= bit_count + 5'd1;
          if (bit_count == 5'd4)
            out_shift <= rd_data;
        end
        // Read data starts with the sixth rise; earlier bits stay low
        if (sclk_rise && bit_count >= 5'd5) begin
          spi_sdo_out <= out_shift[10];
          out_shift <= {out_shift[9:0], 1'b0};
        end
      end
    end
  end

  // Register writes
  always @(posedge clk_in) begin
    if (reset_in) begin
      amp_ctrl <= `AMP_CTRL_RESET;
      drv_ctrl <= `DRV_CTRL_RESET;
      gate_hs <= `GATE_HS_RESET;
      gate_ls <= `GATE_LS_RESET;
      locked <= 1'b0;
    end else begin
      // Fault clear bit drops by itself after one cycle
      drv_ctrl[0] <= 1'b0;
      if (wr_req) begin
        // lock shields all but lock field and low three control bits
        if (wr_addr == `ADDR_DRV_CTRL) begin
          if (locked)
            drv_ctrl[2:0] <= wr_data[2:0];
          else
            drv_ctrl <= wr_data;
        end else if (wr_addr == `ADDR_GATE_HS) begin
          // only the exact codes change lock
          if (!locked && wr_data[10:8] == `LOCK_CODE)
            locked <= 1'b1;
          else if (locked && wr_data[10:8] == `UNLOCK_CODE)
            locked <= 1'b0;
          if (!locked)
            gate_hs <= wr_data[7:0];
        end else if (wr_addr == `ADDR_GATE_LS) begin
          if (!locked)
            gate_ls <= wr_data;
        end else if (wr_addr == `ADDR_AMP_CTRL && HAS_AMPS != 0) begin
          if (!locked) begin
            amp_ctrl <= wr_data;
            if (wr_data[`AMP_INPUT_SEL_BIT])
              amp_ctrl[`LOWSIDE_MONITOR_REF_SELECT_BIT] <= 1'b1;
          end
        end
      end
    end
  end

  // Peak drive window from the time field; hardware parts use longest
  wire [1:0] tdrive_sel = (SPI_VARIANT != 0) ? gate_ls[9:8] : 2'h3;
  reg [7:0] tdrive_limit;
  // Counts round down, so a window may close a fraction early
  localparam [31:0] TDRIVE0_LIM = `TDRIVE0_CYC;
  localparam [31:0] TDRIVE1_LIM = `TDRIVE1_CYC;
  localparam [31:0] TDRIVE2_LIM = `TDRIVE2_CYC;
  localparam [31:0] TDRIVE3_LIM = `TDRIVE3_CYC;
  always @* begin
    case (tdrive_sel)
      2'h0: tdrive_limit = TDRIVE0_LIM[7:0];
      2'h1: tdrive_limit = TDRIVE1_LIM[7:0];
      2'h2: tdrive_limit = TDRIVE2_LIM[7:0];
      default: tdrive_limit = TDRIVE3_LIM[7:0];
    endcase
  end

  // Gate turn-on watch
  reg [7:0] drive_timer;
  reg drive_watch;
  always @(posedge clk_in) begin
    if (reset_in) begin
      drive_timer <= 8'h00;
      drive_watch <= 1'b0;
      gate_fault <= 1'b0;
    end else begin
      if (gcmd_sync[1] && !gcmd_prev) begin
        drive_watch <= 1'b1;
        drive_timer <= 8'h00;
      end else if (drive_watch) begin
        if (gok_sync[1] || !gcmd_sync[1])
          drive_watch <= 1'b0;
        else
          drive_timer <= drive_timer + 8'h01;
      end
      // Timer runs on after a trip; the latch keeps the fault
      // timeout latches fault; set beats clear
      if (drive_watch && !gok_sync[1] && gcmd_sync[1]
          && drive_timer + 8'h01 >= tdrive_limit)
        gate_fault <= 1'b1;
      else if (drv_ctrl[0])
        gate_fault <= 1'b0;
    end
  end

  // Decoded outputs
  wire [10:0] amp_eff = (HAS_AMPS != 0) ? amp_ctrl : 11'h000;
  always @(posedge clk_in) begin
    if (reset_in) begin
      amp_input_select_out <= 1'b0;
      ref_half_out <= 1'b0;
      lowside_monitor_ref_select_out <= 1'b0;
      amp_gain_vv_out <= 6'h00;
      offset_cal_short_out <= 3'h0;
      sense_trip_mv_out <= 10'h000;
      sense_fault_out <= 1'b0;
      drive_source_hs_out <= 4'hf;
      drive_sink_hs_out <= 4'hf;
      drive_source_ls_out <= 4'hf;
      drive_sink_ls_out <= 4'hf;
      gate_drive_fault_out <= 1'b0;
      locked_out <= 1'b0;
    end else begin
      amp_input_select_out <= amp_eff[`AMP_INPUT_SEL_BIT];
      ref_half_out <= amp_eff[`REF_HALF_BIT];
      lowside_monitor_ref_select_out <= amp_eff[`LOWSIDE_MONITOR_REF_SELECT_BIT];
      case (amp_eff[`GAIN_HI:`GAIN_LO])
        2'h0: amp_gain_vv_out <= 6'd5;
        2'h1: amp_gain_vv_out <= 6'd10;
        2'h2: amp_gain_vv_out <= 6'd20;
        default: amp_gain_vv_out <= 6'd40;
      endcase
      // offset calibration shorts, A in bit 2
      offset_cal_short_out <= amp_eff[`CAL_HI:`CAL_LO];
      case (amp_eff[`TRIP_HI:`TRIP_LO])
        2'h0: sense_trip_mv_out <= 10'd250;
        2'h1: sense_trip_mv_out <= 10'd500;
        2'h2: sense_trip_mv_out <= 10'd750;
        default: sense_trip_mv_out <= 10'd1000;
      endcase
      sense_fault_out <= (HAS_AMPS != 0) & socp_sync[1]
                         & ~amp_eff[`SENSE_DIS_BIT];
      if (SPI_VARIANT != 0) begin
        drive_source_hs_out <= gate_hs[7:4];
        drive_sink_hs_out <= gate_hs[3:0];
        drive_source_ls_out <= gate_ls[7:4];
        drive_sink_ls_out <= gate_ls[3:0];
      end else begin
        drive_source_hs_out <= pin_code;
        drive_sink_hs_out <= pin_code;
        drive_source_ls_out <= pin_code;
        drive_sink_ls_out <= pin_code;
      end
      gate_drive_fault_out <= gate_fault;
      locked_out <= locked;
    end
  end

endmodule

// ===== hdl/sense_amp_defs.vh
// Constants for the sense amplifier control register bank.
// Assumes a 25 MHz system clock and a 16-bit SPI frame from the host.
// Summary of operation
// - Input-select 0 routes the sense pin to the amplifier, 1 the node pin.
// - Writing input-select as 1 also sets the low-side reference select to 1.
// - Reference halving 0 gives the full reference, 1 half; it resets to 1.
// - Low-side reference select 0 measures node to sense pin, 1 to neg pin.
// - Gain codes 00, 01, 10, 11 give 5, 10, 20, 40 V/V; reset code is 10.
// - Sense fault disable 0 passes the sense overcurrent fault, 1 hides it.
// - Calibration bit A shorts amplifier A inputs while set.
// - Calibration bit B shorts amplifier B inputs while set.
// - Calibration bit C shorts amplifier C inputs while set.
// - Trip level codes 00 to 11 give 0.25, 0.5, 0.75, 1 V; reset code is 11.
// - The amplifier register sits at address 6 only on amplifier variants.
// - Serial variants set source and sink currents per side by registers.
// - Hardware variants take source and sink together from one pin code.
// - A gate that is not fully on within the peak drive time raises a fault.
// - Code 110 locks out writes but lock and low control bits; 011 unlocks.
`ifndef SENSE_AMP_DEFS_VH
`define SENSE_AMP_DEFS_VH

`define ADDR_STATUS 4'h0
`define ADDR_DRV_CTRL 4'h2
`define ADDR_GATE_HS 4'h3
`define ADDR_GATE_LS 4'h4
`define ADDR_AMP_CTRL 4'h6

`define AMP_CTRL_RESET 11'h283
`define DRV_CTRL_RESET 11'h000
`define GATE_HS_RESET 8'hff
`define GATE_LS_RESET 11'h7ff

`define LOCK_CODE 3'h6
`define UNLOCK_CODE 3'h3

`define AMP_INPUT_SEL_BIT 10
`define REF_HALF_BIT 9
`define LOWSIDE_MONITOR_REF_SELECT_BIT 8
`define GAIN_HI 7
`define GAIN_LO 6
`define SENSE_DIS_BIT 5
`define CAL_HI 4
`define CAL_LO 2
`define TRIP_HI 1
`define TRIP_LO 0

`define CLK_PERIOD_NS 40
`define TDRIVE0_NS 500
`define TDRIVE1_NS 1000
`define TDRIVE2_NS 2000
`define TDRIVE3_NS 4000
`define TDRIVE0_CYC (`TDRIVE0_NS / `CLK_PERIOD_NS)
`define TDRIVE1_CYC (`TDRIVE1_NS / `CLK_PERIOD_NS)
`define TDRIVE2_CYC (`TDRIVE2_NS / `CLK_PERIOD_NS)
`define TDRIVE3_CYC (`TDRIVE3_NS / `CLK_PERIOD_NS)

`endif

// ===== testbench/sense_amp_control_assertions.sv
// Checker for the sense amplifier register bank, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module sense_amp_checker (
  input logic clk_in,
  input logic reset_in,
  input logic spi_cs_n_in,
  input logic spi_sdo_oe_n_out,
  input logic sense_overcurrent_in,
  input logic gate_drive_cmd_in,
  input logic gate_on_ok_in,
  input logic amp_input_select_out,
  input logic ref_half_out,
  input logic lowside_monitor_ref_select_out,
  input logic [5:0] amp_gain_vv_out,
  input logic [2:0] offset_cal_short_out,
  input logic [9:0] sense_trip_mv_out,
  input logic sense_fault_out,
  input logic gate_drive_fault_out,
  input logic locked_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Cycles of a gate command without the gate reported fully on
  logic [7:0] stuck;
  always @(posedge clk_in) begin
    if (reset_in || !gate_drive_cmd_in || gate_on_ok_in)
      stuck <= 8'h00;
    else if (stuck != 8'hff)
      stuck <= stuck + 8'h01;
  end
  reset_values_a: assert property ($fell(reset_in) |-> ##[0:2]
    (amp_gain_vv_out == 6'd20 && sense_trip_mv_out == 10'd1000 &&
    ref_half_out && !amp_input_select_out)) else $error("bad reset");
  gain_codes_a: assert property (!$past(reset_in) |->
    amp_gain_vv_out inside {6'd5, 6'd10, 6'd20, 6'd40}) else $error("gain");
  trip_codes_a: assert property (!$past(reset_in) |->
    sense_trip_mv_out inside {10'd250, 10'd500, 10'd750, 10'd1000})
    else $error("trip level");
  ref_forced_a: assert property (amp_input_select_out |->
    lowside_monitor_ref_select_out) else $error("ref not forced");
  lock_hold_a: assert property (locked_out && $past(locked_out) |->
    $stable(amp_gain_vv_out) && $stable(sense_trip_mv_out))
    else $error("write while locked");
  idle_stable_a: assert property (spi_cs_n_in [*8] |->
    $stable(offset_cal_short_out) && $stable(amp_input_select_out))
    else $error("change without frame");
  oe_idle_a: assert property (spi_cs_n_in [*6] |-> spi_sdo_oe_n_out)
    else $error("sdo driven idle");
  oe_drive_a: assert property (!spi_cs_n_in [*6] |-> !spi_sdo_oe_n_out)
    else $error("sdo not driven");
  fault_off_a: assert property (!sense_overcurrent_in [*5] |->
    !sense_fault_out) else $error("sense fault without cause");
  gate_fault_a: assert property (stuck == 8'd110 |->
    gate_drive_fault_out) else $error("gate fault missing");
  cover property ($rose(locked_out));
  cover property ($rose(gate_drive_fault_out));
  cover property ($rose(amp_input_select_out));
endmodule
bind sense_amp_control sense_amp_checker u_sense_amp_checker (.*);

// ===== testbench/sense_amp_host.sv
// Host side SPI master model for the sense amplifier register bank.
// Assumes clk_in is the device clock; all pins change at its falling edge.
`timescale 1ns/10ps
module sense_amp_host (
  // Clock and returned data
  input wire clk_in,
  input wire sdo_in,
  // Serial pins toward the device
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic xfer(input logic [15:0] f, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (5) @(negedge clk_in);
    // Whole 16-bit frame, MSB first; SDI moves on the rising SCLK
    for (int i = 15; i >= 0; i--) begin
      sclk_out = 1'b1;
      sdi_out = f[i];
      repeat (5) @(negedge clk_in);
      rd = {rd[14:0], sdo_in};
      sclk_out = 1'b0;
      repeat (5) @(negedge clk_in);
    end
    cs_n_out = 1'b1;
    // Released line shows the inverse, never a stale bit
    sdi_out = ~sdi_out;
    repeat (6) @(negedge clk_in);
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the sense amplifier register bank.
// Assumes the host model above and the default SPI amplifier variant.
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sclk, cs_n, sdi, sdo, oe_n, sel, half, ls, sf, gf, lk;
  logic oc = 1'b0;
  logic cmd = 1'b0;
  logic ok = 1'b0;
  logic [3:0] ds = 4'h0;
  logic [3:0] sh, kh, sl, kl;
  logic [3:0] hsh, hkh, hsl, hkl;
  logic hgf;
  logic [5:0] gain;
  logic [2:0] cal;
  logic [9:0] trip;
  logic [15:0] rd;
  logic [15:0] rnd = 16'h000f;
  logic [10:0] d, e;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clk_in = ~clk_in;
  sense_amp_host u_sense_amp_host (.clk_in(clk_in), .sdo_in(sdo),
    .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
  sense_amp_control u_sense_amp_control (.clk_in(clk_in),
    .reset_in(reset_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_n_out(oe_n),
    .drive_strength_pin_in(ds), .sense_overcurrent_in(oc),
    .gate_drive_cmd_in(cmd), .gate_on_ok_in(ok),
    .amp_input_select_out(sel), .ref_half_out(half),
    .lowside_monitor_ref_select_out(ls), .amp_gain_vv_out(gain),
    .offset_cal_short_out(cal), .sense_trip_mv_out(trip),
    .sense_fault_out(sf), .drive_source_hs_out(sh), .drive_sink_hs_out(kh),
    .drive_source_ls_out(sl), .drive_sink_ls_out(kl),
    .gate_drive_fault_out(gf), .locked_out(lk));
  // Pin-strapped variant: drive strength from the code pins
  sense_amp_control #(.HAS_AMPS(1), .SPI_VARIANT(0))
    u_sense_amp_control_hw (.clk_in(clk_in), .reset_in(reset_in),
    .spi_sclk_in(1'b0), .spi_cs_n_in(1'b1), .spi_sdi_in(1'b0),
    .spi_sdo_out(), .spi_sdo_oe_n_out(), .drive_strength_pin_in(ds),
    .sense_overcurrent_in(oc), .gate_drive_cmd_in(cmd),
    .gate_on_ok_in(ok), .amp_input_select_out(), .ref_half_out(),
    .lowside_monitor_ref_select_out(), .amp_gain_vv_out(),
    .offset_cal_short_out(), .sense_trip_mv_out(), .sense_fault_out(),
    .drive_source_hs_out(hsh), .drive_sink_hs_out(hkh),
    .drive_source_ls_out(hsl), .drive_sink_ls_out(hkl),
    .gate_drive_fault_out(hgf), .locked_out());
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [5:0] gain_of(input logic [1:0] c);
    return 6'd5 << c;
  endfunction
  function automatic logic [9:0] trip_of(input logic [1:0] c);
    return 10'd250 + 10'd250 * c;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] v);
    u_sense_amp_host.xfer({1'b0, a, v}, rd);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [10:0] v);
    u_sense_amp_host.xfer({1'b1, a, 11'h000}, rd);
    chk(32'(rd), 32'(v));
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rdchk(4'h6, 11'h283);
    chk(32'({half, gain, trip}), 32'({1'b1, 6'd20, 10'd1000}));
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      oc = rnd[11];
      ds = rnd[15:12];
      d = (i < 4) ? {1'b0, rnd[9:8], i[1:0], rnd[5:2], i[1:0]} : rnd[10:0];
      wr(4'h6, d);
      e = d | {2'b00, d[10], 8'h00};
      rdchk(4'h6, e);
      chk(32'({sel, half, ls, cal}), 32'({e[10:8], e[4:2]}));
      chk(32'({gain, trip}), 32'({gain_of(e[7:6]), trip_of(e[1:0])}));
      chk(32'(sf), 32'(oc & ~e[5]));
      chk(32'({hsh, hkh, hsl, hkl}), 32'({4{ds}}));
    end
    rdchk(4'h7, 11'h000);
    $display("test amp fields done");
    wr(4'h3, 11'h3a5);
    wr(4'h4, 11'h05c);
    chk(32'({sh, kh, sl, kl}), 32'h0000a55c);
    wr(4'h3, 11'h6a5);
    wr(4'h6, 11'h0c1);
    chk(32'(lk), 32'h1);
    rdchk(4'h6, e);
    wr(4'h3, 11'h3a5);
    wr(4'h6, 11'h0c1);
    rdchk(4'h6, 11'h0c1);
    $display("test lock done");
    cmd = 1'b1;
    repeat (30) @(negedge clk_in);
    chk(32'(gf), 32'h1);
    cmd = 1'b0;
    rdchk(4'h0, 11'h400);
    wr(4'h2, 11'h001);
    chk(32'(gf), 32'h0);
    cmd = 1'b1;
    repeat (5) @(negedge clk_in);
    ok = 1'b1;
    repeat (30) @(negedge clk_in);
    chk(32'(gf), 32'h0);
    cmd = 1'b0;
    ok = 1'b0;
    // Longest window of 100 cycles: quiet at 90, tripped by 115
    wr(4'h4, 11'h35c);
    cmd = 1'b1;
    repeat (90) @(negedge clk_in);
    chk(32'({gf, hgf}), 32'h0);
    repeat (25) @(negedge clk_in);
    chk(32'({gf, hgf}), 32'h3);
    cmd = 1'b0;
    $display("test gate fault done");
    complete_run();
  end
endmodule
